/* src/monitor_pulse_train_output.sv */
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module monitor_pulse_train_output #(
    parameter bit          LARGE_CAP   = 1'b0,
    parameter logic [15:0] RATED_CURR  = fm_pkg::CURR_REF_RESET,
    parameter logic [15:0] WIDTH_RESET = 16'(fm_pkg::WIDTH_RESET_CYC)
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // Monitored quantities, same clock domain
    input  wire logic [15:0] SPEED_VAL,
    input  wire logic [15:0] CURR_VAL,
    input  wire logic [15:0] OTHER_VAL,
    input  wire logic [15:0] OTHER_FS,
    // Monitor pulse output
    output logic             MONITOR_PULSE_PIN,
    // AXI4-Lite write address
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // AXI4-Lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    localparam logic [15:0] SPEED_MAX = LARGE_CAP ? fm_pkg::SPEED_MAX_LARGE
                                                  : fm_pkg::SPEED_MAX_SMALL;

    // Reset values outside what the logic can serve stop elaboration
    if (RATED_CURR > fm_pkg::CURR_MAX || WIDTH_RESET > fm_pkg::WIDTH_MAX
            || WIDTH_RESET == 16'h0000) begin : g_bad_reset
        $error("monitor_pulse_train_output: reset value out of range");
    end

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [4:0]  sel;
        logic        vis;
        logic [1:0]  wprot;
        logic [15:0] sref;
        logic [15:0] cref;
        logic [15:0] width;
        logic [31:0] count;
        logic        sat;
        logic        pin;
    } top_st_t;

    top_st_t st_q;
    top_st_t st_d;

    pulse_if pif ();

    pulse_gen u_gen (
        .clk  (CLOCK),
        .nrst (NRST),
        .pif  (pif.gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Rate selection

    logic [15:0] val;
    logic [15:0] fs;
    logic [31:0] num;
    logic [31:0] cap;
    logic [31:0] num_lim;
    logic [15:0] den_lim;
    logic        sat_now;

    // Pick value and full scale by selector
    always_comb begin
        case (st_q.sel)
            fm_pkg::SEL_SPEED: begin
                val = SPEED_VAL;
                fs  = st_q.sref;
            end
            fm_pkg::SEL_CURRENT: begin
                val = CURR_VAL;
                fs  = st_q.cref;
            end
            fm_pkg::SEL_REFERENCE: begin
                val = 16'h0001;
                fs  = 16'h0001;
            end
            default: begin
                val = OTHER_VAL;
                fs  = OTHER_FS;
            end
        endcase
    end

    // Rate is 1440*val/fs, done as a ratio so no divider is needed
    always_comb begin
        num     = 32'(fm_pkg::FULL_SCALE_PPS) * {16'h0000, val};
        cap     = 32'(fm_pkg::CEILING_PPS) * {16'h0000, fs};
        num_lim = num;
        den_lim = fs;
        sat_now = 1'b0;
        // Zero full scale would make the threshold zero; treat any nonzero value as over
        if (fs == 16'h0000) begin
            den_lim = 16'h0001;
            num_lim = (val == 16'h0000) ? 32'h0 : 32'(fm_pkg::CEILING_PPS);
            sat_now = (val != 16'h0000);
        end else if (num > cap) begin
            num_lim = 32'(fm_pkg::CEILING_PPS);
            den_lim = 16'h0001;
            sat_now = 1'b1;
        end
    end

    assign pif.inc   = {16'h0000, num_lim};
    assign pif.thr   = 48'({32'h0, den_lim} * 64'(fm_pkg::CLK_HZ));
    assign pif.width = st_q.width;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    assign AWREADY           = st_q.awready;
    assign WREADY            = st_q.wready;
    assign BVALID            = st_q.bvalid;
    assign BRESP             = st_q.bresp;
    assign ARREADY           = st_q.arready;
    assign RVALID            = st_q.rvalid;
    assign RRESP             = st_q.rresp;
    assign RDATA             = st_q.rdata;
    assign MONITOR_PULSE_PIN = st_q.pin;

    // Byte-lane merge of write data into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] ctrl_word;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp;

    assign ctrl_word = {18'h0, st_q.wprot, 3'h0, st_q.vis, 3'h0, st_q.sel};

    // Read decode; references answer SLVERR with zero data while hidden
    always_comb begin
        rd_val  = 32'h0;
        rd_resp = fm_pkg::RESP_OKAY;
        case (ARADDR)
            fm_pkg::CTRL_OFS:      rd_val = ctrl_word;
            fm_pkg::SPEED_REF_OFS: begin
                if (st_q.vis) begin
                    rd_resp = fm_pkg::RESP_SLVERR;
                end else begin
                    rd_val = {16'h0, st_q.sref};
                end
            end
            fm_pkg::CURR_REF_OFS:  begin
                if (st_q.vis) begin
                    rd_resp = fm_pkg::RESP_SLVERR;
                end else begin
                    rd_val = {16'h0, st_q.cref};
                end
            end
            fm_pkg::WIDTH_CAL_OFS: rd_val = {16'h0, st_q.width};
            fm_pkg::STATUS_OFS:    rd_val = {30'h0, st_q.pin, st_q.sat};
            fm_pkg::PCOUNT_OFS:    rd_val = st_q.count;
            default:               rd_resp = fm_pkg::RESP_SLVERR;
        endcase
    end

    // Next state: bus handshakes, register writes, status
    always_comb begin
        st_d       = st_q;
        wr_val     = 32'h0;
        st_d.pin   = pif.pulse;
        st_d.sat   = sat_now;
        if (pif.tick) begin
            st_d.count = st_q.count + 32'h1;
        end
        // Address and data are taken independently, in either order
        if (AWVALID && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.awaddr  = AWADDR;
            st_d.awready = 1'b0;
        end
        if (WVALID && st_q.wready) begin
            st_d.w_held = 1'b1;
            st_d.wdata  = WDATA;
            st_d.wstrb  = WSTRB;
            st_d.wready = 1'b0;
        end
        if (st_q.bvalid && BREADY) begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = fm_pkg::RESP_OKAY;
            // Write protect is kept for software but never gates these writes
            case (st_q.awaddr)
                fm_pkg::CTRL_OFS: begin
                    wr_val     = merge(ctrl_word, st_q.wdata, st_q.wstrb);
                    st_d.sel   = wr_val[fm_pkg::SEL_LSB +: 5];
                    st_d.vis   = wr_val[fm_pkg::VIS_BIT];
                    st_d.wprot = wr_val[fm_pkg::WPROT_LSB +: 2];
                end
                fm_pkg::SPEED_REF_OFS: begin
                    wr_val = merge({16'h0, st_q.sref}, st_q.wdata, st_q.wstrb);
                    if (st_q.vis || wr_val > {16'h0, SPEED_MAX}) begin
                        st_d.bresp = fm_pkg::RESP_SLVERR;
                    end else begin
                        st_d.sref = wr_val[15:0];
                    end
                end
                fm_pkg::CURR_REF_OFS: begin
                    wr_val = merge({16'h0, st_q.cref}, st_q.wdata, st_q.wstrb);
                    if (st_q.vis || wr_val > {16'h0, fm_pkg::CURR_MAX}) begin
                        st_d.bresp = fm_pkg::RESP_SLVERR;
                    end else begin
                        st_d.cref = wr_val[15:0];
                    end
                end
                fm_pkg::WIDTH_CAL_OFS: begin
                    wr_val = merge({16'h0, st_q.width}, st_q.wdata, st_q.wstrb);
                    // Cap keeps the high time inside the shortest period
                    if (wr_val > {16'h0, fm_pkg::WIDTH_MAX} || wr_val == 32'h0) begin
                        st_d.bresp = fm_pkg::RESP_SLVERR;
                    end else begin
                        st_d.width = wr_val[15:0];
                    end
                end
                fm_pkg::STATUS_OFS, fm_pkg::PCOUNT_OFS: begin
                    st_d.bresp = fm_pkg::RESP_OKAY;
                end
                default: begin
                    st_d.bresp = fm_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Reads: one at a time, address ready drops until data is taken
        if (st_q.rvalid && RREADY) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
        if (ARVALID && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = rd_val;
            st_d.rresp   = rd_resp;
        end
    end

    // State register
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            st_q         <= '0;
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
            st_q.sel     <= fm_pkg::SEL_RESET;
            st_q.sref    <= fm_pkg::SPEED_REF_RESET;
            st_q.cref    <= RATED_CURR;
            st_q.width   <= WIDTH_RESET;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

/* src/fm_pkg.sv */
package fm_pkg;

    // Clock and timing
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          CLK_HZ          = 1000000000 / CLK_PERIOD_NS;
    localparam int          WIDTH_RESET_US  = 200;
    localparam int          WIDTH_RESET_CYC = WIDTH_RESET_US * 1000 / CLK_PERIOD_NS;

    // Pulse rates in pulses per second
    localparam int          FULL_SCALE_PPS  = 1440;
    localparam int          CEILING_PPS     = 2400;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  SPEED_REF_OFS   = 8'h04;
    localparam logic [7:0]  CURR_REF_OFS    = 8'h08;
    localparam logic [7:0]  WIDTH_CAL_OFS   = 8'h0c;
    localparam logic [7:0]  STATUS_OFS      = 8'h10;
    localparam logic [7:0]  PCOUNT_OFS      = 8'h14;

    // Control field positions
    localparam int          SEL_LSB         = 0;
    localparam int          VIS_BIT         = 8;
    localparam int          WPROT_LSB       = 12;

    // Monitor selector codes
    localparam logic [4:0]  SEL_SPEED       = 5'h01;
    localparam logic [4:0]  SEL_CURRENT     = 5'h02;
    localparam logic [4:0]  SEL_REFERENCE   = 5'h15;

    // Values after reset and limits
    localparam logic [4:0]  SEL_RESET       = SEL_SPEED;
    localparam logic [15:0] SPEED_REF_RESET = 16'h0bb8;
    localparam logic [15:0] SPEED_MAX_SMALL = 16'h2ee0;
    localparam logic [15:0] SPEED_MAX_LARGE = 16'h1f40;
    localparam logic [15:0] CURR_MAX        = 16'hc350;
    localparam logic [15:0] CURR_REF_RESET  = 16'h01f4;
    localparam logic [15:0] WIDTH_MAX       = 16'h4e20;

    // Bus answers
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

endpackage

/* src/pulse_if.sv */
`timescale 1ns/1ns
interface pulse_if;
    logic [47:0] inc;
    logic [47:0] thr;
    logic [15:0] width;
    logic        pulse;
    logic        tick;

    modport gen (
        input  inc,
        input  thr,
        input  width,
        output pulse,
        output tick
    );
    modport ctl (
        output inc,
        output thr,
        output width,
        input  pulse,
        input  tick
    );
endinterface

/* src/pulse_gen.sv */
`timescale 1ns/1ns
module pulse_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Rate and width
    pulse_if.gen     pif
);

    typedef struct packed {
        logic [47:0] acc;
        logic [15:0] hold;
        logic        pulse;
        logic        tick;
    } gen_st_t;

    gen_st_t st_q;
    gen_st_t st_d;

    assign pif.pulse = st_q.pulse;
    assign pif.tick  = st_q.tick;

    // Rate accumulator: a pulse each time the sum passes the threshold
    always_comb begin
        logic [47:0] sum;
        sum = '0;
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.acc >= pif.thr) begin
            // Threshold shrank under us; restart the phase cleanly
            st_d.acc = '0;
        end else begin
            sum = st_q.acc + pif.inc;
            if (sum >= pif.thr) begin
                st_d.acc  = sum - pif.thr;
                st_d.tick = 1'b1;
            end else begin
                st_d.acc = sum;
            end
        end
        // High time is reloaded live, so a new width shows on the next pulse
        if (st_d.tick) begin
            st_d.hold = (pif.width == 16'h0000) ? 16'h0001 : pif.width;
        end else if (st_q.hold != 16'h0000) begin
            st_d.hold = st_q.hold - 16'h0001;
        end
        st_d.pulse = (st_d.hold != 16'h0000);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

/* verif/monitor_pulse_train_output_properties.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module monitor_pulse_train_output_properties (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        NRST,
    // Pulse output
    input wire logic        MONITOR_PULSE_PIN,
    // Write channels
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    // Read channels
    input wire logic [7:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY
);
    // Slack for 20 ns quantisation of the shortest period
    localparam int MIN_GAP = 20830;
    logic pin_q;
    int   gap_q;
    int   high_q;

    // Cycles since the last rise and length of the current high phase
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pin_q  <= 1'b0;
            gap_q  <= 0;
            high_q <= 0;
        end else begin
            pin_q  <= MONITOR_PULSE_PIN;
            gap_q  <= (MONITOR_PULSE_PIN && !pin_q) ? 0 : gap_q + 1;
            high_q <= MONITOR_PULSE_PIN ? high_q + 1 : 0;
        end
    end

    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    reset_idle_a: assert property ($rose(NRST) |-> AWREADY && WREADY && ARREADY
        && !BVALID && !RVALID && !MONITOR_PULSE_PIN) else $error("bus or pin not idle");
    rate_ceiling_a: assert property ($rose(MONITOR_PULSE_PIN) |-> gap_q >= MIN_GAP)
        else $error("pulses closer than the ceiling allows");
    width_bound_a: assert property (MONITOR_PULSE_PIN |-> high_q < 20000)
        else $error("pulse high longer than the widest width");
    write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY
        |-> ##[1:2] BVALID) else $error("write response late");
    write_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
    write_release_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
        else $error("write channel not freed");
    read_answer_a: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
        else $error("read data late");
    read_block_a: assert property (RVALID |-> !ARREADY)
        else $error("read taken while data pending");
    unmapped_read_a: assert property (ARVALID && ARREADY && ARADDR > 8'h14
        |-> ##[1:2] (RVALID && RRESP == fm_pkg::RESP_SLVERR && RDATA == 32'h0))
        else $error("unmapped read not refused");
endmodule

bind monitor_pulse_train_output monitor_pulse_train_output_properties
    u_monitor_pulse_train_output_properties (.CLOCK, .NRST, .MONITOR_PULSE_PIN, .AWVALID,
    .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY);

/* verif/pulse_meter.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module pulse_meter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Line from the block
    input  wire logic pin,
    // Readings
    output int        edges,
    output int        period,
    output int        width
);
    logic pin_q;
    int   run_q;
    int   high_q;

    // Digital counter: sampling on the system clock is exact for a registered pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_q  <= 1'b0;
            run_q  <= 0;
            high_q <= 0;
            edges  <= 0;
            period <= 0;
            width  <= 0;
        end else begin
            pin_q  <= pin;
            run_q  <= run_q + 1;
            high_q <= pin ? high_q + 1 : 0;
            if (pin && !pin_q) begin
                edges  <= edges + 1;
                period <= run_q + 1;
                run_q  <= 0;
            end
            if (!pin && pin_q) begin
                width <= high_q;
            end
        end
    end
endmodule

/* verif/monitor_pulse_train_output_bench.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module monitor_pulse_train_output_bench;
    localparam logic [15:0] W_RST = 16'h0014;
    localparam logic [1:0]  OK    = fm_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR   = fm_pkg::RESP_SLVERR;
    logic        CLOCK = 1'b0;
    logic        NRST, MONITOR_PULSE_PIN;
    logic [15:0] SPEED_VAL, CURR_VAL, OTHER_VAL, OTHER_FS;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic        ARVALID, ARREADY, RVALID, RREADY;
    int          m_edges, m_period, m_width;
    int          failures, tests_run, cycles;

    monitor_pulse_train_output #(.WIDTH_RESET(W_RST)) u_monitor_pulse_train_output (.CLOCK,
        .NRST, .SPEED_VAL, .CURR_VAL, .OTHER_VAL, .OTHER_FS, .MONITOR_PULSE_PIN, .AWADDR,
        .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
        .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    pulse_meter u_pulse_meter (.clk(CLOCK), .nrst(NRST), .pin(MONITOR_PULSE_PIN),
        .edges(m_edges), .period(m_period), .width(m_width));

    // 50 MHz clock
    always #10 CLOCK = ~CLOCK;

    // Watchdog: the pulse phase alone needs some 122000 cycles
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 160000) begin
            $display("timeout after %0d cycles", cycles);
            failures = failures + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Tolerance covers quantisation and a few cycles of the old rate after a change
    task automatic chk_near(input string what, input real exp, input int got);
        tests_run++;
        if (got < exp - 12.0 || got > exp + 12.0) begin
            failures++;
            $display("wrong value %s expected %0.1f seen %0d", what, exp, got);
        end
    endtask

    // Handshakes are sampled at the falling edge, acted on at the next rise
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_hs, w_hs, b_hs;
        logic [1:0] r;
        b_hs = 1'b0;
        @(posedge CLOCK);
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        while (!b_hs) begin
            @(negedge CLOCK);
            aw_hs = AWVALID && AWREADY;
            w_hs  = WVALID && WREADY;
            b_hs  = BVALID === 1'b1;
            r     = BRESP;
            @(posedge CLOCK);
            if (aw_hs) AWVALID <= 1'b0;
            if (w_hs) WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        chk_val("write response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0]  r;
        r_hs = 1'b0;
        @(posedge CLOCK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        while (!r_hs) begin
            @(negedge CLOCK);
            ar_hs = ARVALID && ARREADY;
            r_hs  = RVALID === 1'b1;
            d     = RDATA;
            r     = RRESP;
            @(posedge CLOCK);
            if (ar_hs) ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        chk_val("read data", ed, d);
        chk_val("read response", {30'h0, er}, {30'h0, r});
    endtask

    task automatic measure(input string what, input real pps);
        int e;
        @(negedge CLOCK);
        e = m_edges;
        while (m_edges == e) @(negedge CLOCK);
        chk_near(what, 5.0e7 / pps, m_period);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        NRST = 1'b0;
        // Speed far above any reference keeps the rate at the ceiling from reset on
        SPEED_VAL = 16'd30000;
        CURR_VAL = 16'd0;
        OTHER_VAL = 16'd3;
        OTHER_FS = 16'd1;
        {AWADDR, ARADDR, WDATA, WSTRB} = {8'h00, 8'h00, 32'h0, 4'hf};
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
        {failures, tests_run, cycles} = {32'd0, 32'd0, 32'd0};
        repeat (3) @(posedge CLOCK);
        NRST <= 1'b1;
        rd_chk(fm_pkg::CTRL_OFS, 32'h1, OK);
        rd_chk(fm_pkg::SPEED_REF_OFS, 32'h0bb8, OK);
        rd_chk(fm_pkg::CURR_REF_OFS, 32'h01f4, OK);
        rd_chk(fm_pkg::WIDTH_CAL_OFS, {16'h0, W_RST}, OK);
        wr_chk(fm_pkg::SPEED_REF_OFS, 32'd12001, ERR);
        wr_chk(fm_pkg::SPEED_REF_OFS, 32'd12000, OK);
        rd_chk(fm_pkg::SPEED_REF_OFS, 32'h2ee0, OK);
        wr_chk(fm_pkg::CURR_REF_OFS, 32'd50001, ERR);
        wr_chk(fm_pkg::CURR_REF_OFS, 32'd50000, OK);
        wr_chk(fm_pkg::WIDTH_CAL_OFS, 32'h0, ERR);
        wr_chk(fm_pkg::CTRL_OFS, 32'h1001, OK);
        wr_chk(fm_pkg::SPEED_REF_OFS, 32'd3000, OK);
        wr_chk(fm_pkg::CURR_REF_OFS, 32'd5000, OK);
        wr_chk(fm_pkg::CTRL_OFS, 32'h0101, OK);
        rd_chk(fm_pkg::SPEED_REF_OFS, 32'h0, ERR);
        wr_chk(fm_pkg::CURR_REF_OFS, 32'd600, ERR);
        wr_chk(fm_pkg::CTRL_OFS, 32'h1, OK);
        rd_chk(fm_pkg::CURR_REF_OFS, 32'h1388, OK);
        rd_chk(8'h18, 32'h0, ERR);
        wr_chk(8'h18, 32'h1, ERR);
        // Other quantity at three times its full scale stays at the ceiling
        wr_chk(fm_pkg::CTRL_OFS, 32'h3, OK);
        rd_chk(fm_pkg::STATUS_OFS, 32'h1, OK);
        wr_chk(fm_pkg::CTRL_OFS, 32'h1, OK);
        $display("test registers done");
        // Settings change a few cycles after a rise; the rate falls to 2160, rises to 2304
        // or the phase restarts, and the carried phase stays inside the tolerance
        measure("settling", 2400.0);
        repeat (60) @(negedge CLOCK);
        chk_val("high width", {16'h0, W_RST}, 32'(m_width));
        rd_chk(fm_pkg::STATUS_OFS, 32'h1, OK);
        measure("capped period", 2400.0);
        @(posedge CLOCK);
        SPEED_VAL <= 16'd4500;
        wr_chk(fm_pkg::WIDTH_CAL_OFS, 32'd50, OK);
        measure("speed period", 2160.0);
        @(posedge CLOCK);
        CURR_VAL <= 16'd8000;
        wr_chk(fm_pkg::CTRL_OFS, {27'h0, fm_pkg::SEL_CURRENT}, OK);
        repeat (60) @(negedge CLOCK);
        chk_val("high width", 32'd50, 32'(m_width));
        measure("current period", 2304.0);
        // Loads drop only after the switch, so the old phase overruns and restarts
        @(posedge CLOCK);
        wr_chk(fm_pkg::CTRL_OFS, {27'h0, fm_pkg::SEL_REFERENCE}, OK);
        SPEED_VAL <= 16'd0;
        CURR_VAL <= 16'd0;
        measure("reference period", 1440.0);
        rd_chk(fm_pkg::PCOUNT_OFS, 32'h5, OK);
        $display("test pulse train done");
        print_verdict();
    end
endmodule
